// *** rxf_host_path.sv ***
// rxf_host_path: receive FIFOs, host register port and tx halt handshake

// Functional notes
// - a halt request lets a frame already being sent finish first
// - after final tx status, clear halt and run bits, pulse halted
// - setting run again restarts; queued tx frames are sent
// - received bytes go into the data FIFO, pointer advancing per word
// - each packet ends with its status word in a separate status FIFO
// - a level register shows queued data bytes and status words
// - status words may be popped ahead of their data
// - reading an empty FIFO raises the receive error flag
// - packet data starts after a programmable 0 to 31 byte offset
// - optional filler makes each packet a whole number of bursts
// - offset and padding apply to every packet on its own
// - skip bit discards the head packet of the data FIFO
// - skip bit clears when done; no data reads meanwhile
// - skip leaves the status FIFO untouched
// - skip works while reception keeps running
// - dump returns all pointers of both FIFOs to reset
// - dump only after receiver halt; dump bit self-clears
// - status word: length 29:16, filter 30, broadcast 13, mismatch 12
// - bit 15 is the OR of bits 11, 7, 6 and 1
// - clearing receive enable halts reception and pulses halted
// - status FIFO overrun or underrun also raises the error flag
module rxf_host_path
#(
   parameter int DAW = 9,
   parameter int SAW = 4
) (
   input  wire logic                    clock,
   input  wire logic                    reset_n,
   input  wire rxf_pkg::rxf_reg_req_t   reg_req,
   output logic [31:0]                  reg_rdata,
   input  wire logic                    mac_byte_valid,
   input  wire logic [7:0]              mac_byte,
   input  wire logic                    mac_byte_last,
   input  wire rxf_pkg::rxf_frame_sts_t mac_frame_sts,
   output logic                         mac_byte_ready,
   output logic                         rx_mac_enable,
   output logic                         rx_halted_irq,
   output logic                         rx_error_flag,
   output logic                         rx_skip_packet,
   input  wire logic                    tx_frame_active,
   input  wire logic                    tx_status_valid,
   output logic                         tx_start_allow,
   output logic                         tx_halted_irq
);
   import rxf_pkg::*;

   localparam logic [DAW:0] D_DEPTH = (DAW+1)'(1 << DAW);
   localparam logic [SAW:0] S_DEPTH = (SAW+1)'(1 << SAW);

   function automatic logic hit(input rxf_reg_req_t r, input logic [7:0] a);
      hit = (r.addr == a);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // declarations
   rxf_wr_state_t      wr_state_reg;
   logic [1:0]         lane_reg;
   logic [2:0]         fill_reg;
   logic [4:0]         burst_cnt_reg;
   logic [4:0]         burst_next;
   logic [13:0]        len_reg;
   logic [31:0]        word_reg;
   logic [31:0]        merged;
   rxf_frame_sts_t     sts_hold_reg;
   logic [31:0]        sts_word;
   logic               byte_take;

   logic [4:0]         ofs_reg;
   logic [4:0]         burst_reg;
   logic               dump_reg;
   logic               skip_reg;
   logic               rx_en_reg;
   logic               rx_stopped_reg;
   logic               tx_run_reg;
   logic               tx_halt_reg;
   logic               err_reg;

   logic [DAW:0]       d_wr_ptr_reg;
   logic [DAW:0]       d_rd_ptr_reg;
   logic [DAW:0]       d_level;
   logic               d_empty;
   logic               d_full;
   logic               d_we;
   logic [32:0]        d_wdata;
   logic               d_re;
   logic [32:0]        d_q;
   logic [SAW:0]       s_wr_ptr_reg;
   logic [SAW:0]       s_rd_ptr_reg;
   logic [SAW:0]       s_level;
   logic               s_empty;
   logic               s_full;
   logic               s_we;
   logic [31:0]        s_q;

   logic               data_rd;
   logic               sts_rd;
   logic               host_pop;
   logic               s_pop;
   logic               d_uflow;
   logic               s_uflow;
   logic               s_oflow;
   logic               skip_issue;
   logic               skip_vld_reg;
   logic [DAW:0]       skip_addr_reg;
   logic               skip_hit;
   logic               sel_d_reg;
   logic               sel_s_reg;
   logic [31:0]        rdata_reg;
   logic [15:0]        d_bytes;
   logic [7:0]         s_words;

   ////////////////////////////////////////////////////////////////////////////
   // fifo levels
   assign d_level = d_wr_ptr_reg - d_rd_ptr_reg;
   assign d_empty = (d_level == '0);
   assign d_full  = (d_level == D_DEPTH);
   assign s_level = s_wr_ptr_reg - s_rd_ptr_reg;
   assign s_empty = (s_level == '0);
   assign s_full  = (s_level == S_DEPTH);

   ////////////////////////////////////////////////////////////////////////////
   // write side: offset, packing, padding, status
   always_comb
   begin
      merged = word_reg;
      merged[{lane_reg, 3'b000} +: 8] = mac_byte;
      if (burst_reg == '0 || burst_cnt_reg + 5'd1 == burst_reg)
      begin
         burst_next = '0;
      end
      else
      begin
         burst_next = burst_cnt_reg + 5'd1;
      end
   end

   assign byte_take = (wr_state_reg == WR_DATA) && mac_byte_valid && !d_full;
   assign mac_byte_ready = ((wr_state_reg == WR_DATA) && !d_full)
                           || ((wr_state_reg == WR_IDLE) && !rx_en_reg);

   always_comb
   begin
      d_we    = 1'b0;
      d_wdata = {1'b0, FILL_WORD};
      unique case (wr_state_reg)
         WR_OFFSET:
         begin
            d_we = (fill_reg != '0) && !d_full;
         end
         WR_DATA:
         begin
            d_we    = byte_take && (lane_reg == 2'd3 || mac_byte_last);
            d_wdata = {mac_byte_last && burst_next == '0, merged};
         end
         WR_PAD:
         begin
            d_we    = !d_full;
            d_wdata = {burst_next == '0, FILL_WORD};
         end
         WR_IDLE, WR_STATUS:
         begin
            d_we = 1'b0;
         end
      endcase
      if (dump_reg)
      begin
         d_we = 1'b0;
      end
   end

   // status word layout
   assign sts_word = {1'b0, sts_hold_reg.filter_fail, len_reg,
                      sts_hold_reg.runt | sts_hold_reg.too_long
                      | sts_hold_reg.collision | sts_hold_reg.crc_error,
                      1'b0, sts_hold_reg.broadcast,
                      sts_hold_reg.length_mismatch, sts_hold_reg.runt,
                      sts_hold_reg.multicast, 2'b00, sts_hold_reg.too_long,
                      sts_hold_reg.collision, sts_hold_reg.frame_type,
                      sts_hold_reg.watchdog, sts_hold_reg.mii_error,
                      sts_hold_reg.dribble, sts_hold_reg.crc_error, 1'b0};

   assign s_we    = (wr_state_reg == WR_STATUS) && !s_full && !dump_reg;
   assign s_oflow = (wr_state_reg == WR_STATUS) && s_full && !dump_reg;

   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         wr_state_reg  <= WR_IDLE;
         lane_reg      <= '0;
         fill_reg      <= '0;
         burst_cnt_reg <= '0;
         len_reg       <= '0;
         word_reg      <= '0;
         sts_hold_reg  <= '0;
      end
      else if (dump_reg)
      begin
         wr_state_reg <= WR_IDLE;
      end
      else
      begin
         unique case (wr_state_reg)
            WR_IDLE:
            begin
               if (rx_en_reg && mac_byte_valid)
               begin
                  // per packet setup of offset and burst count
                  wr_state_reg  <= WR_OFFSET;
                  fill_reg      <= ofs_reg[4:2];
                  lane_reg      <= ofs_reg[1:0];
                  burst_cnt_reg <= '0;
                  len_reg       <= '0;
               end
            end
            WR_OFFSET:
            begin
               if (fill_reg == '0)
               begin
                  wr_state_reg <= WR_DATA;
               end
               else if (d_we)
               begin
                  fill_reg      <= fill_reg - 3'd1;
                  burst_cnt_reg <= burst_next;
               end
            end
            WR_DATA:
            begin
               if (byte_take)
               begin
                  word_reg <= merged;
                  len_reg  <= len_reg + 14'd1;
                  if (d_we)
                  begin
                     lane_reg      <= '0;
                     burst_cnt_reg <= burst_next;
                  end
                  else
                  begin
                     lane_reg <= lane_reg + 2'd1;
                  end
                  if (mac_byte_last)
                  begin
                     sts_hold_reg <= mac_frame_sts;
                     wr_state_reg <= (burst_next != '0) ? WR_PAD : WR_STATUS;
                  end
               end
            end
            WR_PAD:
            begin
               if (d_we)
               begin
                  burst_cnt_reg <= burst_next;
                  if (burst_next == '0)
                  begin
                     wr_state_reg <= WR_STATUS;
                  end
               end
            end
            WR_STATUS:
            begin
               wr_state_reg <= WR_IDLE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read side: host pops and packet skip
   assign data_rd  = reg_req.rd && hit(reg_req, ADDR_RX_DATA);
   assign sts_rd   = reg_req.rd && hit(reg_req, ADDR_RX_STS);
   assign host_pop = data_rd && !d_empty && !skip_reg;
   assign d_uflow  = data_rd && d_empty;
   assign s_pop    = sts_rd && !s_empty;
   assign s_uflow  = sts_rd && s_empty;

   assign skip_hit   = skip_vld_reg && d_q[32];
   assign skip_issue = skip_reg && !d_empty && !skip_hit;
   assign d_re       = host_pop || skip_issue;

   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         d_wr_ptr_reg  <= '0;
         d_rd_ptr_reg  <= '0;
         s_wr_ptr_reg  <= '0;
         s_rd_ptr_reg  <= '0;
         skip_vld_reg  <= 1'b0;
         skip_addr_reg <= '0;
      end
      else if (dump_reg)
      begin
         d_wr_ptr_reg <= '0;
         d_rd_ptr_reg <= '0;
         s_wr_ptr_reg <= '0;
         s_rd_ptr_reg <= '0;
         skip_vld_reg <= 1'b0;
      end
      else
      begin
         if (d_we)
         begin
            d_wr_ptr_reg <= d_wr_ptr_reg + 1'b1;
         end
         if (s_we)
         begin
            s_wr_ptr_reg <= s_wr_ptr_reg + 1'b1;
         end
         if (s_pop)
         begin
            s_rd_ptr_reg <= s_rd_ptr_reg + 1'b1;
         end
         skip_vld_reg  <= skip_issue;
         skip_addr_reg <= d_rd_ptr_reg;
         if (skip_hit)
         begin
            // resume right after the end-of-packet word, wrap bit included
            d_rd_ptr_reg <= skip_addr_reg + 1'b1;
         end
         else if (d_re)
         begin
            d_rd_ptr_reg <= d_rd_ptr_reg + 1'b1;
         end
      end
   end

   // data words carry an end-of-packet marker in bit 32
   rxf_mem #(
      .W  (33),
      .AW (DAW)
   ) u_data_mem (
      .clock   (clock),
      .reset_n (reset_n),
      .we      (d_we),
      .waddr   (d_wr_ptr_reg[DAW-1:0]),
      .wdata   (d_wdata),
      .re      (d_re),
      .raddr   (d_rd_ptr_reg[DAW-1:0]),
      .rdata   (d_q)
   );

   rxf_mem #(
      .W  (32),
      .AW (SAW)
   ) u_sts_mem (
      .clock   (clock),
      .reset_n (reset_n),
      .we      (s_we),
      .waddr   (s_wr_ptr_reg[SAW-1:0]),
      .wdata   (sts_word),
      .re      (s_pop),
      .raddr   (s_rd_ptr_reg[SAW-1:0]),
      .rdata   (s_q)
   );

   ////////////////////////////////////////////////////////////////////////////
   // control registers
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         ofs_reg   <= RST_OFS;
         burst_reg <= RST_BURST;
         dump_reg  <= 1'b0;
         skip_reg  <= 1'b0;
         rx_en_reg <= 1'b0;
      end
      else
      begin
         dump_reg <= 1'b0;
         if (reg_req.wr && hit(reg_req, ADDR_RX_CFG))
         begin
            ofs_reg   <= reg_req.wdata[CFG_OFS_LSB +: CFG_OFS_W];
            burst_reg <= reg_req.wdata[CFG_BURST_LSB +: CFG_BURST_W];
            dump_reg  <= reg_req.wdata[CFG_DUMP_BIT];
         end
         if (reg_req.wr && hit(reg_req, ADDR_MAC_CTRL))
         begin
            rx_en_reg <= reg_req.wdata[MAC_RX_MAC_ENABLE_BIT];
         end
         if (skip_hit || dump_reg)
         begin
            skip_reg <= 1'b0;
         end
         else if (reg_req.wr && hit(reg_req, ADDR_PATH_CTRL)
                  && reg_req.wdata[PATH_SKIP_BIT])
         begin
            skip_reg <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // error flag and receiver halt indication
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         err_reg        <= 1'b0;
         rx_stopped_reg <= 1'b1;
         rx_halted_irq  <= 1'b0;
      end
      else
      begin
         if (d_uflow || s_uflow || s_oflow)
         begin
            err_reg <= 1'b1;
         end
         else if (reg_req.wr && hit(reg_req, ADDR_RX_ERR)
                  && reg_req.wdata[ERR_FLAG_BIT])
         begin
            err_reg <= 1'b0;
         end
         rx_halted_irq <= 1'b0;
         if (rx_en_reg)
         begin
            rx_stopped_reg <= 1'b0;
         end
         else if (!rx_stopped_reg && wr_state_reg == WR_IDLE)
         begin
            rx_stopped_reg <= 1'b1;
            rx_halted_irq  <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // transmitter halt and restart
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         tx_run_reg    <= 1'b0;
         tx_halt_reg   <= 1'b0;
         tx_halted_irq <= 1'b0;
      end
      else
      begin
         tx_halted_irq <= 1'b0;
         if (tx_halt_reg && (tx_status_valid || !tx_frame_active))
         begin
            tx_run_reg    <= 1'b0;
            tx_halt_reg   <= 1'b0;
            tx_halted_irq <= 1'b1;
         end
         else if (reg_req.wr && hit(reg_req, ADDR_TX_CFG))
         begin
            tx_run_reg  <= reg_req.wdata[TX_RUN_BIT];
            tx_halt_reg <= reg_req.wdata[TX_HALT_BIT];
         end
      end
   end

   assign tx_start_allow = tx_run_reg && !tx_halt_reg;
   assign rx_mac_enable  = rx_en_reg;
   assign rx_error_flag  = err_reg;
   assign rx_skip_packet = skip_reg;

   ////////////////////////////////////////////////////////////////////////////
   // register read back
   assign d_bytes = 16'({d_level, 2'b00});
   assign s_words = 8'(s_level);

   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         rdata_reg <= RDATA_NONE;
         sel_d_reg <= 1'b0;
         sel_s_reg <= 1'b0;
      end
      else
      begin
         sel_d_reg <= host_pop;
         sel_s_reg <= s_pop;
         rdata_reg <= RDATA_NONE;
         if (reg_req.rd)
         begin
            unique case (reg_req.addr)
               ADDR_RX_CFG:
               begin
                  rdata_reg[CFG_OFS_LSB +: CFG_OFS_W]     <= ofs_reg;
                  rdata_reg[CFG_BURST_LSB +: CFG_BURST_W] <= burst_reg;
                  rdata_reg[CFG_DUMP_BIT]                 <= dump_reg;
               end
               ADDR_PATH_CTRL:
               begin
                  rdata_reg[PATH_SKIP_BIT] <= skip_reg;
               end
               ADDR_FIFO_LEVEL:
               begin
                  rdata_reg <= {s_words, 8'h00, d_bytes};
               end
               ADDR_MAC_CTRL:
               begin
                  rdata_reg[MAC_RX_MAC_ENABLE_BIT] <= rx_en_reg;
               end
               ADDR_TX_CFG:
               begin
                  rdata_reg[TX_RUN_BIT]  <= tx_run_reg;
                  rdata_reg[TX_HALT_BIT] <= tx_halt_reg;
               end
               ADDR_RX_ERR:
               begin
                  rdata_reg[ERR_FLAG_BIT]   <= err_reg;
                  rdata_reg[ERR_HALTED_BIT] <= rx_stopped_reg;
               end
               default:
               begin
                  rdata_reg <= RDATA_NONE;
               end
            endcase
         end
      end
   end

   assign reg_rdata = sel_d_reg ? d_q[31:0] : (sel_s_reg ? s_q : rdata_reg);

endmodule

// *** rxf_host_path_checker.sv ***
// port properties of the receive host path
module rxf_host_path_checker
(
   input wire logic                  clock,
   input wire logic                  reset_n,
   input wire rxf_pkg::rxf_reg_req_t reg_req,
   input wire logic [31:0]           reg_rdata,
   input wire logic                  rx_mac_enable,
   input wire logic                  rx_halted_irq,
   input wire logic                  rx_error_flag,
   input wire logic                  rx_skip_packet,
   input wire logic                  tx_frame_active,
   input wire logic                  tx_status_valid,
   input wire logic                  tx_start_allow,
   input wire logic                  tx_halted_irq
);
   import rxf_pkg::*;
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!reset_n);
   sequence pulse_s(s);
      s ##1 !s;
   endsequence
   tx_pulse_a: assert property (tx_halted_irq |-> pulse_s(tx_halted_irq))
      else $error("tx halted pulse too long");
   tx_stopped_a: assert property (tx_halted_irq |-> !tx_start_allow)
      else $error("tx still allowed after halt");
   tx_frame_done_a: assert property (tx_halted_irq |->
      $past(tx_status_valid) || !$past(tx_frame_active))
      else $error("tx halted during a frame");
   rx_pulse_a: assert property (rx_halted_irq |-> pulse_s(rx_halted_irq))
      else $error("rx halted pulse too long");
   rx_halt_cause_a: assert property (rx_halted_irq |-> !rx_mac_enable)
      else $error("rx halted while enabled");
   err_sticky_a: assert property (rx_error_flag && !reg_req.wr |=>
      rx_error_flag)
      else $error("error flag lost");
   skip_refuse_a: assert property (rx_skip_packet && reg_req.rd &&
      reg_req.addr == ADDR_RX_DATA |=> reg_rdata == 32'h0)
      else $error("data read during skip");
   skip_bound_a: assert property ($rose(rx_skip_packet) |->
      ##[1:600] !rx_skip_packet)
      else $error("skip never ends");
endmodule

bind rxf_host_path rxf_host_path_checker i_chk
(
   .clock(clock), .reset_n(reset_n), .reg_req(reg_req),
   .reg_rdata(reg_rdata), .rx_mac_enable(rx_mac_enable),
   .rx_halted_irq(rx_halted_irq), .rx_error_flag(rx_error_flag),
   .rx_skip_packet(rx_skip_packet), .tx_frame_active(tx_frame_active),
   .tx_status_valid(tx_status_valid), .tx_start_allow(tx_start_allow),
   .tx_halted_irq(tx_halted_irq)
);

// *** rxf_mac_model.sv ***
// byte source standing in for the mac layer
module rxf_mac_model
(
   input  wire logic   clock,
   input  wire logic   mac_byte_ready,
   output logic        mac_byte_valid,
   output logic [7:0]  mac_byte,
   output logic        mac_byte_last,
   output logic [11:0] mac_frame_sts
);
   timeunit 1ns;
   timeprecision 1ns;
   logic to_flag = 1'b0;
   initial
   begin
      mac_byte_valid = 1'b0;
      mac_byte_last = 1'b0;
      mac_byte = 8'h00;
      mac_frame_sts = 12'h000;
   end
   // holds each byte until taken or 100 cycles pass; idle lines show a changed value
   task send(input int n, input logic [7:0] b0, input logic [11:0] s);
      int k;
      @(posedge clock);
      for (int i = 0; i < n; i++)
      begin
         mac_byte_valid <= 1'b1;
         mac_byte <= b0 + 8'(i);
         mac_byte_last <= (i == n - 1);
         mac_frame_sts <= s;
         k = 0;
         do
         begin
            @(negedge clock);
            k++;
         end
         while (!mac_byte_ready && k < 100);
         to_flag |= (k == 100);
         @(posedge clock);
      end
      mac_byte_valid <= 1'b0;
      mac_byte_last <= 1'b0;
      mac_byte <= ~mac_byte;
      mac_frame_sts <= ~s;
   endtask
endmodule

// *** rxf_mem.sv ***
// rxf_mem: simple dual-port memory with registered read data
module rxf_mem #(
   parameter int W  = 32,
   parameter int AW = 4
) (
   input  wire logic          clock,
   input  wire logic          reset_n,
   input  wire logic          we,
   input  wire logic [AW-1:0] waddr,
   input  wire logic [W-1:0]  wdata,
   input  wire logic          re,
   input  wire logic [AW-1:0] raddr,
   output logic      [W-1:0]  rdata
);

   logic [W-1:0] store [0:(1<<AW)-1];

   always_ff @(posedge clock)
   begin
      if (we)
      begin
         store[waddr] <= wdata;
      end
   end

   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         rdata <= '0;
      end
      else if (re)
      begin
         rdata <= store[raddr];
      end
   end

endmodule

// *** rxf_pkg.sv ***
// rxf_pkg: shared constants, carriers and states of the receive host path
package rxf_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // register byte addresses
   localparam int          REG_AW          = 8;
   localparam logic [7:0]  ADDR_RX_DATA    = 8'h00;
   localparam logic [7:0]  ADDR_RX_STS     = 8'h04;
   localparam logic [7:0]  ADDR_RX_CFG     = 8'h08;
   localparam logic [7:0]  ADDR_PATH_CTRL  = 8'h0c;
   localparam logic [7:0]  ADDR_FIFO_LEVEL = 8'h10;
   localparam logic [7:0]  ADDR_MAC_CTRL   = 8'h14;
   localparam logic [7:0]  ADDR_TX_CFG     = 8'h18;
   localparam logic [7:0]  ADDR_RX_ERR     = 8'h1c;

   ////////////////////////////////////////////////////////////////////////////
   // register fields
   localparam int CFG_OFS_LSB     = 0;
   localparam int CFG_OFS_W       = 5;
   localparam int CFG_BURST_LSB   = 8;
   localparam int CFG_BURST_W     = 5;
   localparam int CFG_DUMP_BIT    = 15;
   localparam int PATH_SKIP_BIT   = 31;
   localparam int LEVEL_STS_LSB   = 16;
   localparam int MAC_RX_MAC_ENABLE_BIT    = 0;
   localparam int TX_HALT_BIT     = 1;
   localparam int TX_RUN_BIT      = 2;
   localparam int ERR_FLAG_BIT    = 0;
   localparam int ERR_HALTED_BIT  = 1;

   localparam logic [4:0]  RST_OFS    = 5'h00;
   localparam logic [4:0]  RST_BURST  = 5'h00;
   localparam logic [31:0] RDATA_NONE = 32'h0000_0000;
   localparam logic [31:0] FILL_WORD  = 32'h0000_0000;

   ////////////////////////////////////////////////////////////////////////////
   // status word fields
   localparam int STS_LEN_W = 14;

   typedef struct packed {
      logic [REG_AW-1:0] addr;
      logic [31:0]       wdata;
      logic              wr;
      logic              rd;
   } rxf_reg_req_t;

   typedef struct packed {
      logic filter_fail;
      logic broadcast;
      logic length_mismatch;
      logic runt;
      logic multicast;
      logic too_long;
      logic collision;
      logic frame_type;
      logic watchdog;
      logic mii_error;
      logic dribble;
      logic crc_error;
   } rxf_frame_sts_t;

   typedef enum logic [4:0] {
      WR_IDLE   = 5'b00001,
      WR_OFFSET = 5'b00010,
      WR_DATA   = 5'b00100,
      WR_PAD    = 5'b01000,
      WR_STATUS = 5'b10000
   } rxf_wr_state_t;

endpackage

// *** test_rxf_host_path.sv ***
// self-checking bench of the receive host path
module test_rxf_host_path;
   timeunit 1ns;
   timeprecision 1ns;
   import rxf_pkg::*;
   logic           clock = 1'b0;
   logic           reset_n = 1'b0;
   rxf_reg_req_t   reg_req = '0;
   logic [31:0]    reg_rdata, rv, q;
   logic [7:0]     mac_byte;
   rxf_frame_sts_t mac_frame_sts;
   logic           mac_byte_valid, mac_byte_last, mac_byte_ready;
   logic           rx_mac_enable, rx_halted_irq, rx_error_flag;
   logic           rx_skip_packet, tx_start_allow, tx_halted_irq;
   logic           tx_frame_active = 1'b0, tx_status_valid = 1'b0;
   int             n_fail = 0, compares = 0, n_txh = 0, n_rxh = 0;
   rxf_host_path i_dut
   (
      .clock(clock), .reset_n(reset_n), .reg_req(reg_req),
      .reg_rdata(reg_rdata), .mac_byte_valid(mac_byte_valid),
      .mac_byte(mac_byte), .mac_byte_last(mac_byte_last),
      .mac_frame_sts(mac_frame_sts), .mac_byte_ready(mac_byte_ready),
      .rx_mac_enable(rx_mac_enable), .rx_halted_irq(rx_halted_irq),
      .rx_error_flag(rx_error_flag), .rx_skip_packet(rx_skip_packet),
      .tx_frame_active(tx_frame_active),
      .tx_status_valid(tx_status_valid),
      .tx_start_allow(tx_start_allow), .tx_halted_irq(tx_halted_irq)
   );
   rxf_mac_model i_mac
   (
      .clock(clock), .mac_byte_ready(mac_byte_ready),
      .mac_byte_valid(mac_byte_valid), .mac_byte(mac_byte),
      .mac_byte_last(mac_byte_last), .mac_frame_sts(mac_frame_sts)
   );
   initial forever #5 clock = ~clock;
   always @(posedge clock)
   begin
      n_txh <= n_txh + int'(tx_halted_irq);
      n_rxh <= n_rxh + int'(rx_halted_irq);
   end
   ////////////////////////////////////////////////////////////////////////
   task chk(input logic [31:0] g, e, m);
      compares++;
      if ((g & m) !== (e & m))
      begin
         n_fail++;
         $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      reg_req <= '{a, d, 1'b1, 1'b0};
      @(posedge clock);
      reg_req <= '0;
   endtask
   task rd(input logic [7:0] a);
      @(posedge clock);
      reg_req <= '{a, 32'h0, 1'b0, 1'b1};
      @(posedge clock);
      reg_req <= '0;
      #1 rv = reg_rdata;
   endtask
   task finish_test;
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task poll(input logic [7:0] a, input int b, input logic v);
      int k;
      rv = {32{~v}};
      for (k = 0; k < 50 && rv[b] !== v; k++)
         rd(a);
      if (rv[b] !== v)
      begin
         n_fail++;
         finish_test;
      end
   endtask
   task t_reset;
      @(posedge clock) reset_n <= 1'b0;
      repeat (6) @(posedge clock);
      reset_n <= 1'b1;
   endtask
   ////////////////////////////////////////////////////////////////////////
   task t_fmt;
      wr(ADDR_MAC_CTRL, 32'h1);
      wr(ADDR_RX_CFG, 32'h0000_0405);
      i_mac.send(6, 8'h01, 12'h601);
      i_mac.send(6, 8'h11, 12'h100);
      repeat (3) @(posedge clock);
      rd(ADDR_FIFO_LEVEL);
      chk(rv, 32'h0200_0020, '1);
      rd(ADDR_RX_STS);
      chk(rv, 32'h0006_b002, '1);
      rd(ADDR_RX_STS);
      chk(rv, 32'h0006_8800, '1);
      for (int p = 0; p < 2; p++)
      begin
         q = 32'(p) * 32'h1010_1000;
         rd(ADDR_RX_DATA);
         rd(ADDR_RX_DATA);
         chk(rv, 32'h0302_0100 + q, 32'hffff_ff00);
         rd(ADDR_RX_DATA);
         chk(rv, 32'h0006_0504 + (q >> 8), 32'h00ff_ffff);
         rd(ADDR_RX_DATA);
      end
      rd(ADDR_FIFO_LEVEL);
      chk(rv, 32'h0, '1);
      $display("t_fmt done");
   endtask
   task t_under;
      rd(ADDR_RX_DATA);
      chk(rv, 32'h0, '1);
      rd(ADDR_RX_ERR);
      chk(rv, 32'h1, 32'h1);
      wr(ADDR_RX_ERR, 32'h1);
      rd(ADDR_RX_STS);
      rd(ADDR_RX_ERR);
      chk(rv, 32'h1, 32'h1);
      t_reset;
      $display("t_under done");
   endtask
   task t_skip;
      wr(ADDR_MAC_CTRL, 32'h1);
      i_mac.send(20, 8'h40, 12'h000);
      repeat (3) @(posedge clock);
      wr(ADDR_PATH_CTRL, 32'h8000_0000);
      rd(ADDR_RX_DATA);
      chk(rv, 32'h0, '1);
      i_mac.send(4, 8'hb0, 12'h000);
      poll(ADDR_PATH_CTRL, 31, 1'b0);
      rd(ADDR_FIFO_LEVEL);
      chk(rv, 32'h0200_0004, '1);
      rd(ADDR_RX_DATA);
      chk(rv, 32'hb3b2_b1b0, '1);
      rd(ADDR_RX_STS);
      chk(rv, 32'h0014_0000, '1);
      rd(ADDR_RX_STS);
      $display("t_skip done");
   endtask
   task t_rxhalt;
      int n0;
      i_mac.send(4, 8'h70, 12'h000);
      n0 = n_rxh;
      wr(ADDR_MAC_CTRL, 32'h0);
      poll(ADDR_RX_ERR, 1, 1'b1);
      chk(32'(n_rxh - n0), 32'h1, '1);
      wr(ADDR_RX_CFG, 32'h0000_8000);
      rd(ADDR_FIFO_LEVEL);
      chk(rv, 32'h0, '1);
      wr(ADDR_MAC_CTRL, 32'h1);
      $display("t_rxhalt done");
   endtask
   task t_tx;
      int n0;
      n0 = n_txh;
      wr(ADDR_TX_CFG, 32'h4);
      #1 chk({31'h0, tx_start_allow}, 32'h1, '1);
      @(posedge clock);
      tx_frame_active <= 1'b1;
      wr(ADDR_TX_CFG, 32'h6);
      repeat (8) @(posedge clock);
      chk(32'(n_txh - n0), 32'h0, '1);
      tx_frame_active <= 1'b0;
      tx_status_valid <= 1'b1;
      @(posedge clock);
      tx_status_valid <= 1'b0;
      poll(ADDR_TX_CFG, 2, 1'b0);
      chk(rv, 32'h0, 32'h6);
      chk(32'(n_txh - n0), 32'h1, '1);
      wr(ADDR_TX_CFG, 32'h4);
      #1 chk({31'h0, tx_start_allow}, 32'h1, '1);
      $display("t_tx done");
   endtask
   initial
   begin
      t_reset;
      t_fmt;
      t_under;
      t_skip;
      t_rxhalt;
      t_tx;
      chk({31'h0, i_mac.to_flag}, 32'h0, '1);
      finish_test;
   end
endmodule
